/* verilog/sdcd_defines.svh */
// Purpose: constants of the command decode and byte mask block
// Assumes: strobes active low, sampled on rising CLOCK
// Notes: strobe codes are {ras_n, cas_n, we_n}
`ifndef SDCD_DEFINES_SVH
`define SDCD_DEFINES_SVH
`define SDCD_CODE_ACT 3'h3
`define SDCD_CODE_PRE 3'h2
`define SDCD_CODE_WR 3'h4
`define SDCD_CODE_RD 3'h5
`define SDCD_CODE_MRS 3'h0
`define SDCD_CODE_REF 3'h1
`define SDCD_CODE_BST 3'h6
`define SDCD_CODE_NOP 3'h7
`define SDCD_AP_BIT 10
`define SDCD_BANK_BIT 11
`define SDCD_COL_LSB 0
`define SDCD_COL_MSB 7
`define SDCD_MASK_LAT 2
`define SDCD_BURST_FULL 4'h0
`endif

/* verilog/sdcd_pkg.sv */
// Purpose: types of the command decode and byte mask block
// Assumes: nothing beyond the header
// Notes: none
`default_nettype none
package sdcd_pkg;
	typedef enum logic [3:0] {
		CMD_DESEL, CMD_NOP, CMD_ROW_OPEN, CMD_BANK_CLOSE, CMD_ALL_CLOSE, CMD_WRITE,
		CMD_READ, CMD_MODE_SET, CMD_TIMED_REFRESH, CMD_SELF_ENTRY, CMD_BURST_STOP
	} sdcd_cmd_t;
	typedef enum logic [1:0] {PWR_RUN, PWR_SUSPEND, PWR_DOWN, PWR_SELF} sdcd_pwr_t;
endpackage
`default_nettype wire

/* verilog/sdcd_fifo.sv */
// Purpose: small first-in first-out buffer for accepted write words
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty are exact; push while full is refused by ready
`default_nettype none
module sdcd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q;
	logic push, pop;
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_q];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	a_fifo_no_over: assert property (@(posedge clk) disable iff (rst)
		cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count over depth");
endmodule // sdcd_fifo

/* verilog/sdcd_mask_pipe.sv */
// Purpose: read-side byte mask delay line
// Assumes: mask sampled each edge, no state kept beyond the delay
// Notes: each lane delayed independently
`default_nettype none
`include "sdcd_defines.svh"
module sdcd_mask_pipe #(
	parameter int LAT = `SDCD_MASK_LAT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] mask_in,
	output logic [1:0] mask_out
);
	logic [1:0] pipe_q [LAT];
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < LAT; i++) begin
				pipe_q[i] <= 2'h0;
			end
		end else begin
			pipe_q[0] <= mask_in;
			for (int i = 1; i < LAT; i++) begin
				pipe_q[i] <= pipe_q[i-1];
			end
		end
	end
	assign mask_out = pipe_q[LAT-1];
	a_mask_two_late: assert property (@(posedge clk) disable iff (rst)
		##2 (mask_out == $past(mask_in, 2))) else $error("read mask delay wrong");
endmodule // sdcd_mask_pipe

/* verilog/sdcd_top.sv */
// Purpose: command decoder, power-mode tracker and byte masking of a two-bank SDRAM
// Assumes: all inputs synchronous to CLOCK; burst length given as a plain input
// Notes: memory array is outside; write words leave through a FIFO
`default_nettype none
`include "sdcd_defines.svh"
module sdcd_top
	import sdcd_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESET,
	// command strobes
	input wire logic CS_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic CKE,
	input wire logic [11:0] ADDR,
	input wire logic [3:0] BURST_LEN,
	// byte masks
	input wire logic LOW_BYTE_MASK,
	input wire logic HIGH_BYTE_MASK,
	// data pins
	input wire logic [15:0] DQ_IN,
	output logic [15:0] DQ_OUT,
	output logic [1:0] DQ_OE,
	// memory array side
	input wire logic [15:0] RD_DATA,
	output logic WR_VALID,
	input wire logic WR_READY,
	output logic [15:0] WR_DATA,
	output logic [1:0] WR_LANES,
	output logic [7:0] COLUMN,
	// status
	output logic [3:0] LAST_CMD,
	output logic [1:0] BANK_ACTIVE,
	output logic [1:0] POWER_MODE,
	output logic BURST_ACTIVE,
	output logic BURST_WRITE,
	output logic AUTO_CLOSE,
	output logic MODE_SET_PULSE,
	output logic REFRESH_PULSE,
	output logic FIFO_STALL
);
	sdcd_cmd_t cmd_d, cmd_q;
	sdcd_pwr_t pwr_q;
	logic cke_q;
	logic [1:0] bank_act_q;
	logic burst_q, burst_wr_q, auto_q, burst_bank_q;
	logic [3:0] left_q;
	logic [7:0] col_q;
	logic [15:0] dq_out_q;
	logic [1:0] oe_q;
	logic [1:0] rd_mask;
	logic cmd_ok, frozen, idle_nop, bank;
	logic fifo_ready;
	logic [17:0] fifo_out;

	function automatic sdcd_cmd_t decode(input logic cs_n, input logic [2:0] code,
		input logic cke_now, input logic a10);
		sdcd_cmd_t c;
		c = CMD_NOP;
		if (cs_n) begin
			c = CMD_DESEL;
		end else begin
			case (code)
				`SDCD_CODE_ACT: c = CMD_ROW_OPEN;
				`SDCD_CODE_PRE: c = a10 ? CMD_ALL_CLOSE : CMD_BANK_CLOSE;
				`SDCD_CODE_WR: c = CMD_WRITE;
				`SDCD_CODE_RD: c = CMD_READ;
				`SDCD_CODE_MRS: c = CMD_MODE_SET;
				`SDCD_CODE_REF: c = cke_now ? CMD_TIMED_REFRESH : CMD_SELF_ENTRY;
				`SDCD_CODE_BST: c = CMD_BURST_STOP;
				default: c = CMD_NOP;
			endcase
		end
		return c;
	endfunction

	// inputs are used only at the edge, so decode directly from the pins
	assign idle_nop = CS_N || ({RAS_N, CAS_N, WE_N} == `SDCD_CODE_NOP);
	assign bank = ADDR[`SDCD_BANK_BIT];
	assign cmd_ok = cke_q && (pwr_q == PWR_RUN);
	assign frozen = (pwr_q != PWR_RUN);
	always_comb begin
		cmd_d = cmd_ok ? decode(CS_N, {RAS_N, CAS_N, WE_N}, CKE, ADDR[`SDCD_AP_BIT]) : CMD_DESEL;
		// mode set and both refresh kinds need every bank idle, else they act as no-op
		if ((cmd_d == CMD_MODE_SET || cmd_d == CMD_TIMED_REFRESH || cmd_d == CMD_SELF_ENTRY)
			&& bank_act_q != 2'h0) begin
			cmd_d = CMD_NOP;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			cke_q <= 1'b0;
			cmd_q <= CMD_DESEL;
		end else begin
			cke_q <= CKE;
			cmd_q <= cmd_d;
		end
	end

	// power mode tracking
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			pwr_q <= PWR_RUN;
		end else begin
			case (pwr_q)
				PWR_RUN: begin
					if (cmd_d == CMD_SELF_ENTRY && bank_act_q == 2'h0) begin
						pwr_q <= PWR_SELF;
					end else if (cke_q && !CKE) begin
						if (bank_act_q != 2'h0 || burst_q) begin
							pwr_q <= PWR_SUSPEND;
						end else if (idle_nop) begin
							pwr_q <= PWR_DOWN;
						end
					end
				end
				PWR_SUSPEND: begin
					if (!cke_q && CKE) begin
						pwr_q <= PWR_RUN;
					end
				end
				PWR_DOWN: begin
					if (!cke_q && CKE && idle_nop) begin
						pwr_q <= PWR_RUN;
					end
				end
				PWR_SELF: begin
					if (!cke_q && CKE && idle_nop) begin
						pwr_q <= PWR_RUN;
					end
				end
				default: pwr_q <= PWR_RUN;
			endcase
		end
	end

	// bank states
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			bank_act_q <= 2'h0;
		end else begin
			case (cmd_d)
				CMD_ROW_OPEN: begin
					if (!bank_act_q[bank]) begin
						bank_act_q[bank] <= 1'b1;
					end
				end
				CMD_BANK_CLOSE: bank_act_q[bank] <= 1'b0;
				CMD_ALL_CLOSE: bank_act_q <= 2'h0;
				default: begin
					if (burst_q && auto_q && !frozen && left_q == 4'h1) begin
						bank_act_q[burst_bank_q] <= 1'b0;
					end
				end
			endcase
		end
	end

	// burst tracking; full page runs until stopped
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			burst_q <= 1'b0;
			burst_wr_q <= 1'b0;
			auto_q <= 1'b0;
			burst_bank_q <= 1'b0;
			left_q <= 4'h0;
			col_q <= 8'h00;
		end else if ((cmd_d == CMD_READ || cmd_d == CMD_WRITE) && bank_act_q[bank]) begin
			// the command edge carries the first word, so a burst of one ends here
			burst_q <= (BURST_LEN != 4'h1);
			burst_wr_q <= (cmd_d == CMD_WRITE);
			auto_q <= ADDR[`SDCD_AP_BIT] && (BURST_LEN != `SDCD_BURST_FULL);
			burst_bank_q <= bank;
			left_q <= (BURST_LEN == `SDCD_BURST_FULL) ? `SDCD_BURST_FULL : BURST_LEN - 4'h1;
			col_q <= ADDR[`SDCD_COL_MSB:`SDCD_COL_LSB];
		end else if (cmd_d == CMD_BURST_STOP || cmd_d == CMD_BANK_CLOSE
			|| cmd_d == CMD_ALL_CLOSE) begin
			burst_q <= 1'b0;
			auto_q <= 1'b0;
		end else if (burst_q && !frozen && !(cke_q && !CKE)) begin
			col_q <= col_q + 8'h01;
			if (left_q == 4'h1) begin
				burst_q <= 1'b0;
				auto_q <= 1'b0;
			end
			if (left_q != `SDCD_BURST_FULL) begin
				left_q <= left_q - 4'h1;
			end
		end
	end

	// read data path, output frozen in suspend
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			dq_out_q <= 16'h0000;
			oe_q <= 2'h0;
		end else if (!frozen) begin
			dq_out_q <= RD_DATA;
			oe_q[1] <= burst_q && !burst_wr_q && !rd_mask[1] && !HIGH_BYTE_MASK;
			oe_q[0] <= burst_q && !burst_wr_q && !rd_mask[0] && !LOW_BYTE_MASK;
		end
	end

	sdcd_mask_pipe u_mask (
		.clk(CLOCK),
		.rst(RESET),
		.mask_in({HIGH_BYTE_MASK, LOW_BYTE_MASK}),
		.mask_out(rd_mask)
	);

	// write path; lanes with mask high are dropped
	logic wr_push;
	assign wr_push = !frozen && ((cmd_d == CMD_WRITE && bank_act_q[bank])
		|| (burst_q && burst_wr_q && cmd_d != CMD_BURST_STOP && cmd_d != CMD_READ));
	sdcd_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CLOCK),
		.rst(RESET),
		.in_valid(wr_push),
		.in_ready(fifo_ready),
		.in_data({!HIGH_BYTE_MASK, !LOW_BYTE_MASK, DQ_IN}),
		.out_valid(WR_VALID),
		.out_ready(WR_READY),
		.out_data(fifo_out)
	);
	assign WR_DATA = fifo_out[15:0];
	assign WR_LANES = fifo_out[17:16];
	// a full buffer loses the word; the flag lets the controller back off
	assign FIFO_STALL = !fifo_ready;

	assign DQ_OUT = dq_out_q;
	assign DQ_OE = oe_q;
	assign COLUMN = col_q;
	assign LAST_CMD = cmd_q;
	assign BANK_ACTIVE = bank_act_q;
	assign POWER_MODE = pwr_q;
	assign BURST_ACTIVE = burst_q;
	assign BURST_WRITE = burst_wr_q;
	assign AUTO_CLOSE = auto_q;
	assign MODE_SET_PULSE = (cmd_q == CMD_MODE_SET);
	assign REFRESH_PULSE = (cmd_q == CMD_TIMED_REFRESH);

	a_deselect_ignored: assert property (@(posedge CLOCK) disable iff (RESET)
		CS_N |=> (cmd_q == CMD_DESEL)) else $error("deselect decoded as command");
	a_cke_gate: assert property (@(posedge CLOCK) disable iff (RESET)
		!cke_q |=> (cmd_q == CMD_DESEL)) else $error("command without prior enable");
	a_suspend_entry: assert property (@(posedge CLOCK) disable iff (RESET)
		(pwr_q == PWR_RUN && cke_q && !CKE && bank_act_q != 2'h0 && cmd_d != CMD_SELF_ENTRY)
		|=> (pwr_q == PWR_SUSPEND)) else $error("suspend not entered");
	a_suspend_exit: assert property (@(posedge CLOCK) disable iff (RESET)
		(pwr_q == PWR_SUSPEND && !cke_q && CKE) |=> (pwr_q == PWR_RUN))
		else $error("suspend not left");
	a_down_exit: assert property (@(posedge CLOCK) disable iff (RESET)
		(pwr_q == PWR_DOWN && !cke_q && CKE && idle_nop) |=> (pwr_q == PWR_RUN))
		else $error("power down not left");
	a_no_down_burst: assert property (@(posedge CLOCK) disable iff (RESET)
		(pwr_q == PWR_RUN && burst_q && cke_q && !CKE) |=> (pwr_q != PWR_DOWN))
		else $error("power down during burst");
	a_stop_ends: assert property (@(posedge CLOCK) disable iff (RESET)
		(cmd_d == CMD_BURST_STOP) |=> !burst_q) else $error("burst stop ignored");
	a_all_close: assert property (@(posedge CLOCK) disable iff (RESET)
		(cmd_d == CMD_ALL_CLOSE) |=> (bank_act_q == 2'h0)) else $error("banks not closed");
	a_mask_lane: assert property (@(posedge CLOCK) disable iff (RESET)
		(!frozen && HIGH_BYTE_MASK) |=> !oe_q[1]) else $error("masked lane driven");
	a_undef_nop: assert property (@(posedge CLOCK) disable iff (RESET)
		(cmd_d == CMD_NOP && !(burst_q && auto_q && !frozen && left_q == 4'h1))
		|=> $stable(bank_act_q)) else $error("no-op changed banks");
endmodule // sdcd_top
`default_nettype wire

/* bench/sdcd_ctrl_model.sv */
// Purpose: memory controller stand-in driving commands, masks and write data
// Assumes: one command per rising edge, nonblocking drive
// Notes: strobes given as {ras_n, cas_n, we_n} codes
`default_nettype none
module sdcd_ctrl_model (
	// clock
	input wire logic clk,
	// command
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic cke,
	output logic [11:0] addr,
	// data
	output logic [1:0] mask,
	output logic [15:0] dq
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{cs_n, ras_n, cas_n, we_n, cke} = 5'h1f;
		addr = 12'h000;
		mask = 2'h0;
		dq = 16'h0000;
	end
	// all pins move on one edge, so no command is seen half changed
	task automatic cyc(input logic sel_n, input logic [2:0] code, input logic [11:0] a,
		input logic ck, input logic [1:0] m, input logic [15:0] d);
		@(posedge clk);
		cs_n <= sel_n;
		{ras_n, cas_n, we_n} <= code;
		cke <= ck;
		addr <= a;
		mask <= m;
		dq <= d;
	endtask
endmodule // sdcd_ctrl_model
`default_nettype wire

/* bench/tb_sdcd_top.sv */
// Purpose: self-checking bench of the command decode and byte mask block
// Assumes: controller model drives the pins, bench model tracks banks and write words
// Notes: pulses are counted, not timed
`default_nettype none
`include "sdcd_defines.svh"
module tb_sdcd_top;
	import sdcd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLOCK = 1'b0, RESET = 1'b1, WR_READY = 1'b0, wr_on = 1'b0;
	logic [3:0] BURST_LEN = 4'h2;
	logic [15:0] RD_DATA = 16'h0000;
	logic CS_N, RAS_N, CAS_N, WE_N, CKE, LOW_BYTE_MASK, HIGH_BYTE_MASK, WR_VALID;
	logic BURST_ACTIVE, FIFO_STALL, MODE_SET_PULSE, REFRESH_PULSE;
	logic [11:0] ADDR;
	logic [15:0] DQ_IN, WR_DATA;
	logic [1:0] DQ_OE, WR_LANES, BANK_ACTIVE, POWER_MODE, bopen = 2'b00;
	logic [3:0] LAST_CMD;
	logic [7:0] COLUMN;
	logic [17:0] q[$];
	int seed = 32'hd8cb_ff14;
	int fail_count = 0, cmp_count = 0, cyc_n = 0, ms_n = 0, rf_n = 0;
	always #2 CLOCK = ~CLOCK;
	sdcd_ctrl_model ctl (.clk(CLOCK), .cs_n(CS_N), .ras_n(RAS_N), .cas_n(CAS_N),
		.we_n(WE_N), .cke(CKE), .addr(ADDR), .mask({HIGH_BYTE_MASK, LOW_BYTE_MASK}),
		.dq(DQ_IN));
	sdcd_top #(.FIFO_DEPTH(8)) uut (.CLOCK, .RESET, .CS_N, .RAS_N, .CAS_N, .WE_N, .CKE,
		.ADDR, .BURST_LEN, .LOW_BYTE_MASK, .HIGH_BYTE_MASK, .DQ_IN, .DQ_OUT(), .DQ_OE,
		.RD_DATA, .WR_VALID, .WR_READY, .WR_DATA, .WR_LANES, .COLUMN, .LAST_CMD,
		.BANK_ACTIVE, .POWER_MODE, .BURST_ACTIVE, .BURST_WRITE(), .AUTO_CLOSE(),
		.MODE_SET_PULSE, .REFRESH_PULSE, .FIFO_STALL);
	always @(posedge CLOCK) begin
		RD_DATA <= 16'($random(seed));
		ms_n += (MODE_SET_PULSE === 1'b1);
		rf_n += (REFRESH_PULSE === 1'b1);
		cyc_n++;
		if (cyc_n == 2000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s exp %h seen %h", n, exp, seen);
		end
	endtask
	// issue one selected command and keep the bench model in step
	task automatic c(input logic [2:0] code, input logic [11:0] a, input logic ck,
		input logic [1:0] m);
		logic [15:0] d;
		d = 16'($random(seed));
		ctl.cyc(1'b0, code, a, ck, m, d);
		if (code == `SDCD_CODE_ACT) bopen[a[11]] = 1'b1;
		if (code == `SDCD_CODE_PRE) bopen = a[10] ? 2'b00 : bopen & ~(2'b01 << a[11]);
		if (wr_on) q.push_back({~m, d & {{8{~m[1]}}, {8{~m[0]}}}});
	endtask
	task automatic idle(input int n, input logic ck, input logic [1:0] m);
		repeat (n) c(`SDCD_CODE_NOP, 12'h000, ck, m);
	endtask
	task automatic st(input logic [1:0] pm, input logic ba);
		@(negedge CLOCK);
		chk("power_mode", POWER_MODE, pm);
		chk("burst_active", BURST_ACTIVE, ba);
		chk("bank_active", BANK_ACTIVE, bopen);
	endtask
	// far side stalls until each word has been inspected
	task automatic drain(input int n);
		logic [17:0] e;
		repeat (n) begin
			e = q.pop_front();
			@(negedge CLOCK);
			chk("wr_valid", WR_VALID, 1'b1);
			chk("wr_lanes", WR_LANES, e[17:16]);
			chk("wr_data", WR_DATA & {{8{e[17]}}, {8{e[16]}}}, e[15:0]);
			@(posedge CLOCK);
			WR_READY <= 1'b1;
			@(posedge CLOCK);
			WR_READY <= 1'b0;
		end
		@(negedge CLOCK);
		chk("wr_empty", WR_VALID, 1'b0);
		q.delete();
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge CLOCK);
		RESET <= 1'b0;
		idle(3, 1, 0);
		c(`SDCD_CODE_ACT, 12'h000, 1, 0);
		c(`SDCD_CODE_ACT, 12'h800, 1, 0);
		idle(2, 1, 0);
		st(PWR_RUN, 0);
		wr_on = 1'b1;
		c(`SDCD_CODE_WR, 12'h012, 1, 2'b01);
		c(`SDCD_CODE_NOP, 12'h000, 1, 2'b10);
		wr_on = 1'b0;
		idle(3, 1, 0);
		drain(2);
		idle(1, 1, 0);
		BURST_LEN <= 4'h0;
		c(`SDCD_CODE_RD, 12'h020, 1, 2'b10);
		idle(4, 1, 2'b10);
		st(PWR_RUN, 1);
		chk("dq_oe", DQ_OE, 2'b01);
		chk("column", COLUMN, 16'h0023);
		idle(4, 1, 0);
		@(negedge CLOCK);
		chk("dq_oe", DQ_OE, 2'b11);
		idle(3, 0, 0);
		st(PWR_SUSPEND, 1);
		idle(3, 1, 0);
		st(PWR_RUN, 1);
		c(`SDCD_CODE_BST, 12'h000, 1, 0);
		idle(2, 1, 0);
		st(PWR_RUN, 0);
		c(`SDCD_CODE_PRE, 12'h800, 1, 0);
		c(`SDCD_CODE_RD, 12'h800, 1, 0);
		c(`SDCD_CODE_REF, 12'h000, 1, 0);
		idle(2, 1, 0);
		st(PWR_RUN, 0);
		chk("refresh_count", 16'(rf_n), 16'h0000);
		c(`SDCD_CODE_PRE, 12'h400, 1, 0);
		c(`SDCD_CODE_MRS, 12'h000, 1, 0);
		c(`SDCD_CODE_REF, 12'h000, 1, 0);
		repeat (3) ctl.cyc(1'b1, `SDCD_CODE_MRS, 12'h000, 1'b1, 2'b00, 16'h0000);
		@(negedge CLOCK);
		chk("last_cmd", LAST_CMD, CMD_DESEL);
		chk("mode_count", 16'(ms_n), 16'h0001);
		chk("refresh_count", 16'(rf_n), 16'h0001);
		idle(3, 0, 0);
		st(PWR_DOWN, 0);
		idle(3, 1, 0);
		st(PWR_RUN, 0);
		c(`SDCD_CODE_REF, 12'h000, 0, 0);
		idle(3, 0, 0);
		st(PWR_SELF, 0);
		idle(3, 1, 0);
		st(PWR_RUN, 0);
		chk("refresh_count", 16'(rf_n), 16'h0001);
		c(`SDCD_CODE_ACT, 12'h000, 1, 0);
		idle(2, 1, 0);
		wr_on = 1'b1;
		c(`SDCD_CODE_WR, 12'h000, 1, 0);
		idle(10, 1, 0);
		wr_on = 1'b0;
		c(`SDCD_CODE_BST, 12'h000, 1, 0);
		idle(2, 1, 0);
		st(PWR_RUN, 0);
		chk("fifo_stall", FIFO_STALL, 1'b1);
		drain(8);
		tally_and_finish();
	end
endmodule // tb_sdcd_top
`default_nettype wire
